//--- buck_sync_consts.svh
// register offsets, field positions, reset values and timing counts of the buck clock block
`ifndef BUCK_SYNC_CONSTS_SVH
`define BUCK_SYNC_CONSTS_SVH

// register offsets on the byte-wide register port
`define OFS_CONFIG       8'h00
`define OFS_CLK_CTRL     8'h01
`define OFS_GPO_CTRL     8'h02
`define OFS_INT_FLAGS    8'h03
`define OFS_INT_MASK     8'h04
`define OFS_MEAS_SEL     8'h05
`define OFS_LOAD_LO      8'h06
`define OFS_LOAD_HI      8'h07
`define OFS_STATUS       8'h08
`define OFS_VOUT0        8'h10
`define OFS_VOUT1        8'h11
`define OFS_BCTRL0       8'h12
`define OFS_BCTRL1       8'h13
`define OFS_BDELAY0      8'h14
`define OFS_BDELAY1      8'h15

// field positions
`define BIT_DITHER_EN    0
`define BIT_PLL_EN       6
`define BIT_GPOA_LVL     0
`define BIT_GPOA_OD      1
`define BIT_GPOB_LVL     2
`define BIT_GPOB_OD      3
`define BIT_SYNC_AS_GPO  4
`define BIT_MEAS_FLAG    0
`define BIT_SYNC_FLAG    1
`define BIT_BUCK_SEL     0
`define BIT_ST_VALID     0
`define BIT_ST_USE_EXT   1
`define BIT_ST_BUSY      2
`define BIT_FPWM         0

// reset values
`define RST_CTRL         12'h000
`define RST_MASK         2'h0

// timing: measurement window and detector gate, then load LSB in mA and top nominal frequency
`define MCLK_MHZ         100
`define MEAS_TIME_US     50
`define MEAS_CYCLES      (`MEAS_TIME_US * `MCLK_MHZ)
`define DET_GATE_US      10
`define DET_CYCLES       (`DET_GATE_US * `MCLK_MHZ)
`define LOAD_LSB_MA      20
`define MAX_NOM_MHZ      24

`endif

//--- buck_sync_pkg.sv
// types shared by the buck clock block
package buck_sync_pkg;
  typedef struct packed {
    logic [7:0] vout;
    logic [2:0] slew;
    logic [1:0] ilim;
    logic fpwm;
    logic [3:0] startDly;
    logic [3:0] shutDly;
  } buckSet_t;
  typedef buckSet_t [1:0] buckPair_t;
  typedef logic [13:0] senseMa_t;
  typedef senseMa_t [1:0] sensePair_t;
  typedef struct packed {
    logic ditherEn;
    logic pllEn;
    logic [4:0] freqCode;
    logic gpoALvl;
    logic gpoAOd;
    logic gpoBLvl;
    logic gpoBOd;
    logic syncAsGpo;
  } ctrl_t;
  typedef enum logic {MEAS_IDLE, MEAS_RUN} measState_t;
endpackage

//--- buck_clock_sync.sv
// clock source selection, sync detection, outputs and load-current measurement of the bucks
`include "buck_sync_consts.svh"

module buck_clock_sync #(
  parameter int MEAS_CYCLES = `MEAS_CYCLES,
  parameter int DET_CYCLES = `DET_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic syncPinIn,
  output logic syncPinOut,
  output logic syncPinOeN,
  output logic gpoAOut,
  output logic gpoAOeN,
  input wire logic otpLoad,
  input wire logic buckStart,
  input wire buck_sync_pkg::buckPair_t otpDefaults,
  input wire buck_sync_pkg::sensePair_t senseMa,
  input wire logic [1:0] heavyLoad,
  output buck_sync_pkg::buckPair_t buckCfg,
  output logic [1:0] pwmMode,
  output logic useExtClk,
  output logic ditherOn,
  output logic irqOut,
  output logic measBusy
);
  import buck_sync_pkg::*;

  if (MEAS_CYCLES < 1 || MEAS_CYCLES > `MEAS_CYCLES) begin : g_bad_meas
    $error("measurement length must be 1 to the 50 us bound");
  end
  if (DET_CYCLES < 16 || DET_CYCLES > 1023) begin : g_bad_det
    $error("detector gate must be 16 to 1023 cycles");
  end

  // nominal frequency in MHz from the field, code 0 is 1 MHz
  function automatic logic [4:0] nomMhz(input logic [4:0] code);
    nomMhz = (code >= 5'(`MAX_NOM_MHZ)) ? 5'(`MAX_NOM_MHZ) : code + 5'h01;
  endfunction

  // edge count over the gate lies in -30%/+10% of nominal, scaled by the real gate length
  function automatic logic inRange(input logic [9:0] edges, input logic [4:0] code);
    logic [20:0] nomEdges;
    logic [20:0] scaled;
    nomEdges = 21'(nomMhz(code)) * 21'(DET_CYCLES);
    scaled = 21'(edges) * 21'(`MCLK_MHZ * 10);
    inRange = (scaled >= nomEdges * 21'h000007) && (scaled <= nomEdges * 21'h00000b);
  endfunction

  // sensed current in mA to result counts, saturating at nine bits
  function automatic logic [8:0] toCounts(input logic [13:0] ma);
    logic [13:0] q;
    q = ma / 14'(`LOAD_LSB_MA);
    toCounts = (q > 14'h01ff) ? 9'h1ff : q[8:0];
  endfunction

  ctrl_t ctrl_reg, ctrl_next;
  buckPair_t buck_reg, buck_next;
  logic [1:0] mask_reg, mask_next;
  logic measFlag_reg, measFlag_next;
  logic syncFlag_reg, syncFlag_next;
  measState_t meas_reg, meas_next;
  logic measSel_reg, measSel_next;
  logic [15:0] measCnt_reg, measCnt_next;
  logic [8:0] result_reg, result_next;
  logic syncPrev_reg, syncPrev_next;
  logic [9:0] gateCnt_reg, gateCnt_next;
  logic [9:0] edgeCnt_reg, edgeCnt_next;
  logic extValid_reg, extValid_next;
  logic [7:0] regRdData_reg, regRdData_next;
  logic syncPinOut_reg, syncPinOut_next, syncPinOeN_reg, syncPinOeN_next;
  logic gpoAOut_reg, gpoAOut_next, gpoAOeN_reg, gpoAOeN_next;
  logic [1:0] pwmMode_reg, pwmMode_next;
  logic useExt_reg, useExt_next, ditherOn_reg, ditherOn_next;
  logic irqOut_reg, irqOut_next;
  logic measStart, measEnd, measClr, syncClr, syncSet;
  logic [15:0] measAge_reg, measAge_next;

  // register writes, OTP defaults, the done flag and the measurement sequence
  always_comb begin
    ctrl_next = ctrl_reg;
    buck_next = buck_reg;
    mask_next = mask_reg;
    meas_next = meas_reg;
    measSel_next = measSel_reg;
    measCnt_next = measCnt_reg;
    result_next = result_reg;
    measStart = regWr && (regAddr == `OFS_MEAS_SEL);
    measClr = regWr && (regAddr == `OFS_INT_FLAGS) && regWrData[`BIT_MEAS_FLAG];
    syncClr = regWr && (regAddr == `OFS_INT_FLAGS) && regWrData[`BIT_SYNC_FLAG];
    measEnd = 1'b0;
    if (otpLoad) begin
      buck_next = otpDefaults;
    end
    if (regWr) begin
      case (regAddr)
        `OFS_CONFIG: ctrl_next.ditherEn = regWrData[`BIT_DITHER_EN];
        `OFS_CLK_CTRL: begin
          ctrl_next.pllEn = regWrData[`BIT_PLL_EN];
          ctrl_next.freqCode = regWrData[4:0];
        end
        `OFS_GPO_CTRL: begin
          ctrl_next.gpoALvl = regWrData[`BIT_GPOA_LVL];
          ctrl_next.gpoAOd = regWrData[`BIT_GPOA_OD];
          ctrl_next.gpoBLvl = regWrData[`BIT_GPOB_LVL];
          ctrl_next.gpoBOd = regWrData[`BIT_GPOB_OD];
          ctrl_next.syncAsGpo = regWrData[`BIT_SYNC_AS_GPO];
        end
        `OFS_INT_MASK: mask_next = regWrData[1:0];
        `OFS_VOUT0: buck_next[0].vout = regWrData;
        `OFS_VOUT1: buck_next[1].vout = regWrData;
        `OFS_BCTRL0: {buck_next[0].ilim, buck_next[0].slew, buck_next[0].fpwm} = regWrData[5:0];
        `OFS_BCTRL1: {buck_next[1].ilim, buck_next[1].slew, buck_next[1].fpwm} = regWrData[5:0];
        `OFS_BDELAY0: {buck_next[0].shutDly, buck_next[0].startDly} = regWrData;
        `OFS_BDELAY1: {buck_next[1].shutDly, buck_next[1].startDly} = regWrData;
        default: ;
      endcase
    end
    case (meas_reg)
      MEAS_IDLE: ;
      MEAS_RUN: begin
        if (measCnt_reg == 16'h0000) begin
          measEnd = 1'b1;
          meas_next = MEAS_IDLE;
          result_next = toCounts(senseMa[measSel_reg]);
        end else begin
          measCnt_next = measCnt_reg - 16'h0001;
        end
      end
      default: meas_next = MEAS_IDLE;
    endcase
    if (measStart) begin
      meas_next = MEAS_RUN; // a new write restarts the sequence
      measSel_next = regWrData[`BIT_BUCK_SEL];
      measCnt_next = 16'(MEAS_CYCLES - 1);
    end
    measFlag_next = (measFlag_reg && !measClr) || measEnd;
  end

  // busy cycles since the last start, kept apart from the down-counter for the bound check
  always_comb begin
    measAge_next = measAge_reg;
    if (measStart) begin
      measAge_next = 16'h0000;
    end else if (meas_reg == MEAS_RUN) begin
      measAge_next = measAge_reg + 16'h0001;
    end
  end

  // sync clock detector: counts pin edges over a fixed gate
  always_comb begin
    syncPrev_next = syncPinIn;
    gateCnt_next = gateCnt_reg;
    edgeCnt_next = edgeCnt_reg;
    extValid_next = extValid_reg;
    if (!ctrl_next.pllEn) begin
      gateCnt_next = 10'h000;
      edgeCnt_next = 10'h000;
      extValid_next = 1'b0;
    end else if (gateCnt_reg == 10'(DET_CYCLES - 1)) begin
      gateCnt_next = 10'h000;
      edgeCnt_next = 10'h000;
      extValid_next = inRange(edgeCnt_reg, ctrl_reg.freqCode);
    end else begin
      gateCnt_next = gateCnt_reg + 10'h001;
      if (syncPinIn && !syncPrev_reg && edgeCnt_reg != 10'h3ff) begin
        edgeCnt_next = edgeCnt_reg + 10'h001;
      end
    end
    syncSet = (ctrl_reg.pllEn && ctrl_next.pllEn && (extValid_next != extValid_reg))
      || (ctrl_reg.pllEn && (otpLoad || buckStart) && !extValid_reg);
    syncFlag_next = (syncFlag_reg && !syncClr) || syncSet;
  end

  // registered outputs and read data
  always_comb begin
    regRdData_next = regRdData_reg;
    if (regRd) begin
      case (regAddr)
        `OFS_CONFIG: regRdData_next = {7'h00, ctrl_reg.ditherEn};
        `OFS_CLK_CTRL: regRdData_next = {1'b0, ctrl_reg.pllEn, 1'b0, ctrl_reg.freqCode};
        `OFS_GPO_CTRL: regRdData_next = {3'h0, ctrl_reg.syncAsGpo, ctrl_reg.gpoBOd,
          ctrl_reg.gpoBLvl, ctrl_reg.gpoAOd, ctrl_reg.gpoALvl};
        `OFS_INT_FLAGS: regRdData_next = {6'h00, syncFlag_reg, measFlag_reg};
        `OFS_INT_MASK: regRdData_next = {6'h00, mask_reg};
        `OFS_MEAS_SEL: regRdData_next = {7'h00, measSel_reg};
        `OFS_LOAD_LO: regRdData_next = result_reg[7:0];
        `OFS_LOAD_HI: regRdData_next = {7'h00, result_reg[8]};
        `OFS_STATUS: regRdData_next = {5'h00, meas_reg == MEAS_RUN, useExt_reg, extValid_reg};
        `OFS_VOUT0: regRdData_next = buck_reg[0].vout;
        `OFS_VOUT1: regRdData_next = buck_reg[1].vout;
        `OFS_BCTRL0: regRdData_next = {2'h0, buck_reg[0].ilim, buck_reg[0].slew, buck_reg[0].fpwm};
        `OFS_BCTRL1: regRdData_next = {2'h0, buck_reg[1].ilim, buck_reg[1].slew, buck_reg[1].fpwm};
        `OFS_BDELAY0: regRdData_next = {buck_reg[0].shutDly, buck_reg[0].startDly};
        `OFS_BDELAY1: regRdData_next = {buck_reg[1].shutDly, buck_reg[1].startDly};
        default: regRdData_next = 8'h00;
      endcase
    end
    gpoAOut_next = ctrl_next.gpoALvl;
    gpoAOeN_next = ctrl_next.gpoAOd && ctrl_next.gpoALvl;
    syncPinOut_next = ctrl_next.gpoBLvl;
    syncPinOeN_next = !ctrl_next.syncAsGpo || (ctrl_next.gpoBOd && ctrl_next.gpoBLvl);
    for (int i = 0; i < 2; i++) begin
      pwmMode_next[i] = buck_next[i].fpwm || heavyLoad[i]
        || (meas_next == MEAS_RUN && measSel_next == 1'(i));
    end
    useExt_next = ctrl_next.pllEn && extValid_next;
    ditherOn_next = ctrl_next.ditherEn && !ctrl_next.pllEn;
    irqOut_next = (measFlag_next && !mask_next[`BIT_MEAS_FLAG])
      || (syncFlag_next && !mask_next[`BIT_SYNC_FLAG]);
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `RST_CTRL;
      buck_reg <= '0;
      mask_reg <= `RST_MASK;
      measFlag_reg <= 1'b0;
      syncFlag_reg <= 1'b0;
      meas_reg <= MEAS_IDLE;
      measSel_reg <= 1'b0;
      measCnt_reg <= 16'h0000;
      result_reg <= 9'h000;
      syncPrev_reg <= 1'b0;
      gateCnt_reg <= 10'h000;
      edgeCnt_reg <= 10'h000;
      extValid_reg <= 1'b0;
      regRdData_reg <= 8'h00;
      syncPinOut_reg <= 1'b0;
      syncPinOeN_reg <= 1'b1;
      gpoAOut_reg <= 1'b0;
      gpoAOeN_reg <= 1'b0;
      pwmMode_reg <= 2'h0;
      useExt_reg <= 1'b0;
      ditherOn_reg <= 1'b0;
      irqOut_reg <= 1'b0;
      measAge_reg <= 16'h0000;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
      buck_reg <= buck_next;
      mask_reg <= mask_next;
      measFlag_reg <= measFlag_next;
      syncFlag_reg <= syncFlag_next;
      meas_reg <= meas_next;
      measSel_reg <= measSel_next;
      measCnt_reg <= measCnt_next;
      result_reg <= result_next;
      syncPrev_reg <= syncPrev_next;
      gateCnt_reg <= gateCnt_next;
      edgeCnt_reg <= edgeCnt_next;
      extValid_reg <= extValid_next;
      regRdData_reg <= regRdData_next;
      syncPinOut_reg <= syncPinOut_next;
      syncPinOeN_reg <= syncPinOeN_next;
      gpoAOut_reg <= gpoAOut_next;
      gpoAOeN_reg <= gpoAOeN_next;
      pwmMode_reg <= pwmMode_next;
      useExt_reg <= useExt_next;
      ditherOn_reg <= ditherOn_next;
      irqOut_reg <= irqOut_next;
      measAge_reg <= measAge_next;
    end
  end

  // output wiring straight from flip-flops
  assign regRdData = regRdData_reg;
  assign syncPinOut = syncPinOut_reg;
  assign syncPinOeN = syncPinOeN_reg;
  assign gpoAOut = gpoAOut_reg;
  assign gpoAOeN = gpoAOeN_reg;
  assign buckCfg = buck_reg;
  assign pwmMode = pwmMode_reg;
  assign useExtClk = useExt_reg;
  assign ditherOn = ditherOn_reg;
  assign irqOut = irqOut_reg;
  assign measBusy = (meas_reg == MEAS_RUN);

  // checks on the behaviour above
  chk_meas_start: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && measStart |=> meas_reg == MEAS_RUN && measSel_reg == $past(regWrData[0]))
    else $error("measurement did not start on selection write");
  chk_meas_pwm: assert property (@(posedge mclk) disable iff (!rstn)
    meas_reg == MEAS_RUN |-> pwmMode_reg[measSel_reg])
    else $error("measured buck not in PWM");
  chk_meas_bound: assert property (@(posedge mclk) disable iff (!rstn)
    meas_reg == MEAS_RUN |-> measAge_reg < 16'(MEAS_CYCLES))
    else $error("measurement exceeds its time");
  chk_meas_done: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && measEnd && !measStart |=> measFlag_reg && meas_reg == MEAS_IDLE)
    else $error("done flag not set at end of measurement");
  chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
    irqOut_reg == ((measFlag_reg && !mask_reg[0]) || (syncFlag_reg && !mask_reg[1])))
    else $error("interrupt output disagrees with flags and masks");
  chk_dither_gate: assert property (@(posedge mclk) disable iff (!rstn)
    ditherOn_reg == (ctrl_reg.ditherEn && !ctrl_reg.pllEn))
    else $error("dithering while PLL on or disabled");
  chk_pll_off: assert property (@(posedge mclk) disable iff (!rstn)
    !ctrl_reg.pllEn |-> !extValid_reg && !useExt_reg && gateCnt_reg == 10'h000)
    else $error("detector active with PLL off");
  chk_ext_select: assert property (@(posedge mclk) disable iff (!rstn)
    useExt_reg == (ctrl_reg.pllEn && extValid_reg))
    else $error("clock source selection wrong");
  chk_sync_event: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && ctrl_reg.pllEn && ctrl_next.pllEn && extValid_next != extValid_reg
    |=> syncFlag_reg)
    else $error("sync flag missed a clock change");
  chk_flag_hold: assert property (@(posedge mclk) disable iff (!rstn)
    measFlag_reg && !(clkEn && measClr) |=> measFlag_reg)
    else $error("done flag dropped without a clear");
endmodule // buck_clock_sync

//--- buck_sync_source.sv
// external sync clock source model that drives the sync pin
module buck_sync_source (
  input wire logic mclk,
  input wire logic run,
  input wire logic signed [31:0] period,
  output logic syncPin
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  // square wave of period mclk cycles; stands still low while stopped
  always @(negedge mclk) begin
    if (!run || period < 2) begin
      cnt <= 0;
      syncPin <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
      syncPin <= (cnt < period / 2);
    end
  end
endmodule // buck_sync_source

//--- buck_clock_sync_tb_top.sv
// self-checking bench of the buck clock and measurement block
`include "buck_sync_consts.svh"
`define CHK(what, exp, got) begin \
  checkCount++; \
  if ((got) !== (exp)) begin \
    nMismatch++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); \
  end \
end
module buck_clock_sync_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import buck_sync_pkg::*;
  localparam int MC = 20;
  logic mclk = 1'b0, rstn = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic syncPinIn, syncPinOut, syncPinOeN, gpoAOut, gpoAOeN, srcPin, srcRun = 1'b0;
  logic otpLoad = 1'b0, buckStart = 1'b0, useExtClk, ditherOn, irqOut, measBusy;
  logic [1:0] heavyLoad = 2'h0, pwmMode;
  buckPair_t otpDefaults = '0, buckCfg;
  sensePair_t senseMa = '0;
  int srcPeriod = 0, nMismatch = 0, checkCount = 0;
  // pin level: design drives when enabled, else the source
  assign syncPinIn = syncPinOeN ? srcPin : syncPinOut;
  initial forever #5 mclk = ~mclk;
  buck_clock_sync #(.MEAS_CYCLES(MC), .DET_CYCLES(1000)) dut (.mclk(mclk), .rstn(rstn),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .syncPinIn(syncPinIn), .syncPinOut(syncPinOut),
    .syncPinOeN(syncPinOeN), .gpoAOut(gpoAOut), .gpoAOeN(gpoAOeN), .otpLoad(otpLoad),
    .buckStart(buckStart), .otpDefaults(otpDefaults), .senseMa(senseMa),
    .heavyLoad(heavyLoad), .buckCfg(buckCfg), .pwmMode(pwmMode), .useExtClk(useExtClk),
    .ditherOn(ditherOn), .irqOut(irqOut), .measBusy(measBusy));
  buck_sync_source src (.mclk(mclk), .run(srcRun), .period(srcPeriod), .syncPin(srcPin));
  // register port strobes, one cycle each, changed at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge mclk);
    regWr = 1'b0;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input int exp);
    @(negedge mclk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge mclk);
    regRd = 1'b0;
    `CHK(what, exp[7:0], regRdData)
  endtask
  task automatic pulse(input int which);
    @(negedge mclk);
    if (which == 1) otpLoad = 1'b1;
    else buckStart = 1'b1;
    @(negedge mclk);
    otpLoad = 1'b0;
    buckStart = 1'b0;
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // model of the result: 20 mA per count, saturating at the 9-bit limit
  function automatic int measExp(input int ma);
    return (ma / 20 > 511) ? 511 : ma / 20;
  endfunction
  task automatic measure(input int sel, input int mask, input int ma);
    int n;
    int exp;
    senseMa[sel] = ma[13:0];
    senseMa[1 - sel] = 14'($urandom_range(0, 16383));
    exp = measExp(ma);
    wr(`OFS_INT_MASK, mask[7:0]);
    wr(`OFS_MEAS_SEL, sel[7:0]);
    `CHK("measBusy", 1'b1, measBusy)
    @(negedge mclk);
    `CHK("pwmMode", 1'b1, pwmMode[sel])
    n = 1;
    while (measBusy === 1'b1 && n < 1000) begin
      n++;
      @(negedge mclk);
    end
    `CHK("measLen", MC, n)
    `CHK("pwmRelease", 1'b0, pwmMode[sel])
    `CHK("irqOut", (mask == 1) ? 1'b0 : 1'b1, irqOut)
    rdChk("loadLo", `OFS_LOAD_LO, exp & 8'hff);
    rdChk("loadHi", `OFS_LOAD_HI, exp >> 8);
    rdChk("flags", `OFS_INT_FLAGS, 1);
    rdChk("measSel", `OFS_MEAS_SEL, sel);
    wr(`OFS_INT_MASK, 8'h00);
    @(negedge mclk);
    `CHK("irqOut", 1'b1, irqOut)
    wr(`OFS_INT_FLAGS, 8'h01);
    @(negedge mclk);
    `CHK("irqOut", 1'b0, irqOut)
    rdChk("flags", `OFS_INT_FLAGS, 0);
  endtask
  // watchdog reckoned at about three times the expected run length
  initial begin
    #(40000 * 10);
    nMismatch++;
    giveVerdict();
  end
  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] w;
    logic [1:0] h;
    static int codeT [4] = '{1, 4, 4, 4};
    static int perT [4] = '{50, 10, 20, 0};
    static int valT [4] = '{1, 0, 1, 0};
    static logic [7:0] zeroT [6] = '{`OFS_CONFIG, `OFS_CLK_CTRL, `OFS_GPO_CTRL, `OFS_INT_FLAGS,
      `OFS_INT_MASK, 8'h20};
    void'($urandom(32'h5970b82c));
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk); // host wait shortened, not enforced by the block
    `CHK("syncPinOeN", 1'b1, syncPinOeN)
    `CHK("gpoAOeN", 1'b0, gpoAOeN)
    for (int i = 0; i < 6; i++) rdChk("resetReg", zeroT[i], 0);
    $display("test reset done");
    otpDefaults = buckPair_t'({$urandom, $urandom});
    pulse(1);
    `CHK("buckCfg", otpDefaults, buckCfg)
    rdChk("vout0", `OFS_VOUT0, otpDefaults[0].vout);
    rdChk("delay1", `OFS_BDELAY1, {otpDefaults[1].shutDly, otpDefaults[1].startDly});
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(`OFS_VOUT0 + 8'(i), d);
      rdChk("buckReg", `OFS_VOUT0 + 8'(i), (i == 2 || i == 3) ? (d & 8'h3f) : d);
    end
    $display("test otp done");
    for (int i = 0; i < 8; i++) begin
      h = 2'($urandom_range(0, 3));
      v = 8'($urandom_range(0, 255));
      w = 8'($urandom_range(0, 255));
      heavyLoad = h;
      wr(`OFS_BCTRL0, v);
      wr(`OFS_BCTRL1, w);
      @(negedge mclk);
      `CHK("pwmMode", {w[0] | h[1], v[0] | h[0]}, pwmMode)
      `CHK("fpwm0", v[0], buckCfg[0].fpwm)
    end
    heavyLoad = 2'h0;
    wr(`OFS_BCTRL0, 8'h00);
    wr(`OFS_BCTRL1, 8'h00);
    $display("test pwm done");
    measure(1, 0, $urandom_range(0, 10219));
    measure(0, 1, 16383);
    measure(1, 0, 10220);
    $display("test measure done");
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom_range(0, 31));
      wr(`OFS_GPO_CTRL, d);
      @(negedge mclk);
      `CHK("gpoAOut", d[0], gpoAOut)
      `CHK("gpoAOeN", d[1] & d[0], gpoAOeN)
      `CHK("syncPinOeN", d[4] ? d[3] & d[2] : 1'b1, syncPinOeN)
      if (d[4]) `CHK("syncPinOut", d[2], syncPinOut)
    end
    wr(`OFS_GPO_CTRL, 8'h00);
    $display("test gpo done");
    @(negedge mclk);
    clkEn = 1'b0;
    wr(`OFS_CONFIG, 8'h01);
    clkEn = 1'b1;
    rdChk("config", `OFS_CONFIG, 0);
    wr(`OFS_CONFIG, 8'h01);
    srcPeriod = 50;
    srcRun = 1'b1;
    wr(`OFS_CLK_CTRL, 8'h01);
    repeat (2500) @(negedge mclk);
    `CHK("ditherOn", 1'b1, ditherOn)
    `CHK("useExtClk", 1'b0, useExtClk)
    rdChk("flags", `OFS_INT_FLAGS, 0);
    for (int i = 0; i < 4; i++) begin
      srcPeriod = perT[i];
      srcRun = (perT[i] != 0);
      wr(`OFS_CLK_CTRL, 8'h40 | codeT[i][7:0]);
      repeat (2500) @(negedge mclk);
      `CHK("useExtClk", valT[i][0], useExtClk)
      `CHK("ditherOn", 1'b0, ditherOn)
      `CHK("irqOut", 1'b1, irqOut)
      rdChk("flags", `OFS_INT_FLAGS, 2);
      rdChk("status", `OFS_STATUS, valT[i] * 3);
      wr(`OFS_INT_FLAGS, 8'h02);
    end
    $display("test sync done");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(`OFS_INT_MASK, 8'h02);
      pulse(k);
      rdChk("flags", `OFS_INT_FLAGS, 2);
      `CHK("irqOut", (k == 1) ? 1'b0 : 1'b1, irqOut)
      wr(`OFS_INT_FLAGS, 8'h02);
    end
    wr(`OFS_CLK_CTRL, 8'h00);
    $display("test missing clock done");
    giveVerdict();
  end
endmodule // buck_clock_sync_tb_top
